/* File: src/cpl_port.sv */
// Purpose: Link setup and flow control for one 10/100 copper port.
// Assumes: PHY-side status inputs are synchronous to CLK.
// Notes:   Registers over a simple strobe port, read data one cycle later.
// Notes on behaviour
// - In auto-negotiation, detect cable wiring and swap pairs automatically.
// - Port mode is fixed 100 megabit or 10/100 auto-negotiation, by software.
// - After reset the port runs auto-negotiation.
// - At fixed speed duplex follows a separate software setting.
// - Negotiated mode ranks 100F, 100H, 10F, 10H; best common one wins.
// - Without negotiation pulses, speed comes from idle; duplex is half.
// - Negotiate again whenever link comes up or returns after loss.
// - At 100 half duplex the port adds fifty bit times path delay.
// - Full duplex with flow control sends pause when buffer nearly full.
// - After pause, send resume once free buffer has grown again.
// - Half duplex with flow control forces collisions while congested.
// - Flow control is switched per port by software and starts disabled.
`include "cpl_cfg.svh"
`default_nettype none
module cpl_port
  import cpl_pkg::*;
#(
  parameter int          AW      = `CPL_BUF_AW,
  parameter logic [AW-1:0] HIGH  = `CPL_BUF_HIGH,
  parameter logic [AW-1:0] LOW   = `CPL_BUF_LOW,
  parameter int          STARTUP = `CPL_STARTUP_CYC
)
(
  input  wire logic          CLK,
  input  wire logic          SYS_RST,
  input  wire logic [3:0]    ADDR,
  input  wire logic [7:0]    WDATA,
  input  wire logic          WR,
  input  wire logic          RD,
  output logic      [7:0]    RDATA,
  input  wire logic          SIGNAL_DET,
  input  wire logic          CROSS_OK,
  input  wire logic          NLP_SEEN,
  input  wire logic [3:0]    PARTNER_ADV,
  input  wire logic          PARTNER_VALID,
  input  wire logic          IDLE_100,
  input  wire logic          IDLE_10,
  input  wire logic [AW-1:0] BUF_LEVEL,
  output logic               MDIX,
  output logic               LINK_UP,
  output logic               SPEED100,
  output logic               FULL,
  output logic               NEGO_START,
  output logic               SEND_PAUSE,
  output logic               SEND_RESUME,
  output logic               FORCE_COL,
  output logic      [7:0]    PATH_DELAY_VALUE
);
  // Control register and local advertisement.
  logic [7:0] ctrl;
  logic [3:0] adv;
  cpl_state_e state;
  cpl_link_s  link;
  logic [15:0] timer;
  logic       paused;
  logic       congested;

  wire ctrl_autoneg = ctrl[`CPL_BIT_AUTONEG];
  wire ctrl_fullset = ctrl[`CPL_BIT_FULL];
  wire ctrl_flowen  = ctrl[`CPL_BIT_FLOWEN];

  // Register decode.
  wire wr_ctrl = WR && (ADDR == `CPL_ADDR_CTRL);
  wire wr_adv  = WR && (ADDR == `CPL_ADDR_ADV);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl <= `CPL_CTRL_RESET;
      adv  <= 4'hF;
    end else begin
      if (wr_ctrl) ctrl <= WDATA;
      if (wr_adv)  adv  <= WDATA[3:0];
    end
  end

  // Read mux; unmapped addresses read zero.
  wire [7:0] stat_word = {3'b000, state == CPL_UP, link.mdix, link.speed100,
                          link.full, paused | congested};
  wire [7:0] rd_mux = (ADDR == `CPL_ADDR_CTRL) ? ctrl :
                      (ADDR == `CPL_ADDR_STAT) ? stat_word :
                      (ADDR == `CPL_ADDR_ADV)  ? {4'h0, adv} :
                      (ADDR == `CPL_ADDR_PATH_DELAY) ? PATH_DELAY_VALUE : 8'h00;

  always_ff @(posedge CLK) begin
    if (SYS_RST) RDATA <= 8'h00;
    else if (RD) RDATA <= rd_mux;
    else         RDATA <= 8'h00;
  end

  cpl_mode_e res_mode;
  logic      res_valid;
  cpl_resolve u_res (
    .clk        (CLK),
    .rst        (SYS_RST),
    .local_adv  (adv),
    .remote_adv (PARTNER_ADV),
    .mode       (res_mode),
    .valid      (res_valid)
  );

  // The resolver is registered, so a fresh page must stand one cycle before its mode is used.
  logic page_ok;
  always_ff @(posedge CLK) begin
    if (SYS_RST) page_ok <= 1'b0;
    else         page_ok <= PARTNER_VALID;
  end

  // A mode change by software restarts the link.
  wire restart = wr_ctrl && (WDATA[2:0] != ctrl[2:0]);
  wire tmo     = (timer == 16'h0000);

  // Link state machine.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state      <= CPL_DOWN;
      link       <= '0;
      timer      <= 16'h0000;
      NEGO_START <= 1'b0;
    end else begin
      NEGO_START <= 1'b0;
      if (timer != 16'h0000) timer <= timer - 16'h0001;
      if (restart || (!SIGNAL_DET && state != CPL_DOWN && state != CPL_SEEK)) begin
        state     <= CPL_DOWN;
        link.up   <= 1'b0;
      end else begin
        case (state)
          CPL_DOWN: begin
            link.up <= 1'b0;
            timer   <= 16'(STARTUP);
            state   <= CPL_SEEK;
          end
          CPL_SEEK: begin
            if (ctrl_autoneg && tmo && !CROSS_OK) begin
              link.mdix <= ~link.mdix;
              timer     <= 16'(STARTUP);
            end else if (SIGNAL_DET && (CROSS_OK || !ctrl_autoneg)) begin
              if (ctrl_autoneg) begin
                state      <= CPL_NEGO;
                NEGO_START <= 1'b1;
                timer      <= 16'(STARTUP);
              end else begin
                state <= CPL_FIXED;
              end
            end
          end
          CPL_NEGO: begin
            if (page_ok && PARTNER_VALID && res_valid) begin
              link.speed100 <= (res_mode == CPL_M100F) || (res_mode == CPL_M100H);
              link.full     <= (res_mode == CPL_M100F) || (res_mode == CPL_M10F);
              state         <= CPL_UP;
            end else if (tmo && !NLP_SEEN) begin
              state <= CPL_PARALLEL;
            end
          end
          CPL_PARALLEL: begin
            if (IDLE_100 || IDLE_10) begin
              link.speed100 <= IDLE_100;
              link.full     <= 1'b0;
              state         <= CPL_UP;
            end
          end
          CPL_FIXED: begin
            link.speed100 <= 1'b1;
            link.full     <= ctrl_fullset;
            state         <= CPL_UP;
          end
          CPL_UP: begin
            link.up <= 1'b1;
          end
          default: state <= CPL_DOWN;
        endcase
      end
    end
  end

  wire above_high = (BUF_LEVEL >= HIGH);
  wire below_low  = (BUF_LEVEL < LOW);
  wire fd_flow    = ctrl_flowen && link.up && link.full;
  wire hd_flow    = ctrl_flowen && link.up && !link.full;

  // Flow control: pause/resume on full duplex, collisions on half duplex.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      paused      <= 1'b0;
      congested   <= 1'b0;
      SEND_PAUSE  <= 1'b0;
      SEND_RESUME <= 1'b0;
      FORCE_COL   <= 1'b0;
    end else begin
      SEND_PAUSE  <= 1'b0;
      SEND_RESUME <= 1'b0;
      if (fd_flow && !paused && above_high) begin
        paused     <= 1'b1;
        SEND_PAUSE <= 1'b1;
      end else if (paused && (below_low || !fd_flow)) begin
        paused      <= 1'b0;
        SEND_RESUME <= 1'b1;
      end
      if (hd_flow && above_high) begin
        congested <= 1'b1;
      end else if (below_low || !hd_flow) begin
        congested <= 1'b0;
      end
      FORCE_COL <= hd_flow && (congested || above_high) && !below_low;
    end
  end

  // Registered link outputs.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      MDIX             <= 1'b0;
      LINK_UP          <= 1'b0;
      SPEED100         <= 1'b0;
      FULL             <= 1'b0;
      PATH_DELAY_VALUE <= 8'h00;
    end else begin
      MDIX     <= link.mdix;
      LINK_UP  <= link.up;
      SPEED100 <= link.speed100;
      FULL     <= link.full;
      PATH_DELAY_VALUE <= (link.up && link.speed100 && !link.full) ?
                          `CPL_PATH_DELAY_BT : 8'h00;
    end
  end
endmodule : cpl_port
`default_nettype wire

/* File: include/cpl_cfg.svh */
// Purpose: Constants for the copper port link and flow control block.
// Assumes: 10 MHz system clock, 100 ns period.
// Notes:   Thresholds are in buffer words; hysteresis lies between them.
`ifndef CPL_CFG_SVH
`define CPL_CFG_SVH

`define CPL_CLK_HZ          10000000
`define CPL_BUF_AW          10
`define CPL_BUF_HIGH        10'h0380
`define CPL_BUF_LOW         10'h0200
`define CPL_PATH_DELAY_BT   8'h32
`define CPL_STARTUP_NS      1000
`define CPL_STARTUP_CYC     ((`CPL_STARTUP_NS * (`CPL_CLK_HZ / 1000000) + 999) / 1000)
`define CPL_ADDR_CTRL       4'h0
`define CPL_ADDR_STAT       4'h4
`define CPL_ADDR_ADV        4'h8
`define CPL_ADDR_PATH_DELAY 4'hC
`define CPL_CTRL_RESET      8'h01
`define CPL_BIT_AUTONEG     0
`define CPL_BIT_SPEED100    1
`define CPL_BIT_FULL        2
`define CPL_BIT_FLOWEN      3

`endif

/* File: include/cpl_pkg.sv */
// Purpose: Types shared by the copper port link block.
// Assumes: Included after cpl_cfg.svh.
// Notes:   Modes are ranked from best to worst.
`default_nettype none
package cpl_pkg;
  typedef enum logic [1:0] {
    CPL_M100F,
    CPL_M100H,
    CPL_M10F,
    CPL_M10H
  } cpl_mode_e;

  typedef struct packed {
    logic       up;
    logic       speed100;
    logic       full;
    logic       mdix;
  } cpl_link_s;

  typedef enum logic [2:0] {
    CPL_DOWN,
    CPL_SEEK,
    CPL_NEGO,
    CPL_PARALLEL,
    CPL_FIXED,
    CPL_UP
  } cpl_state_e;
endpackage : cpl_pkg
`default_nettype wire

/* File: src/cpl_resolve.sv */
// Purpose: Pick the best common mode from two advertised ability sets.
// Assumes: Ability bits ordered 100F, 100H, 10F, 10H from bit 3 down.
// Notes:   Result is registered; valid is low when nothing is shared.
`default_nettype none
module cpl_resolve
  import cpl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] local_adv,
  input  wire logic [3:0] remote_adv,
  output var  cpl_mode_e  mode,
  output var  logic       valid
);
  wire [3:0] common = local_adv & remote_adv;

  // Highest ranked shared mode wins.
  cpl_mode_e next_mode;
  assign next_mode = common[3] ? CPL_M100F :
                     common[2] ? CPL_M100H :
                     common[1] ? CPL_M10F  : CPL_M10H;

  // Register the resolved mode.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode  <= CPL_M10H;
      valid <= 1'b0;
    end else begin
      mode  <= next_mode;
      valid <= |common;
    end
  end
endmodule : cpl_resolve
`default_nettype wire

/* File: sim/cpl_sva.sv */
// Purpose: Port checks for cpl_port.
// Assumes: One clock, synchronous reset.
// Notes:   Flow enable is shadowed from bus writes.
`default_nettype none
module cpl_sva #(
  parameter int            AW   = 10,
  parameter logic [AW-1:0] HIGH = 10'h0380,
  parameter logic [AW-1:0] LOW  = 10'h0200
) (
  input wire logic          CLK, SYS_RST, WR, RD, LINK_UP, SPEED100, FULL,
  input wire logic          SEND_PAUSE, SEND_RESUME, FORCE_COL,
  input wire logic [3:0]    ADDR,
  input wire logic [7:0]    WDATA, RDATA, PATH_DELAY_VALUE,
  input wire logic [AW-1:0] BUF_LEVEL
);
  logic fl;
  logic pz;
  // Shadows the flow enable bit and an open pause.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      fl <= 1'b0;
      pz <= 1'b0;
    end else begin
      if (WR && ADDR == 4'h0) fl <= WDATA[3];
      pz <= SEND_PAUSE || (pz && !SEND_RESUME);
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  property p_rd; !$past(RD) |-> RDATA == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data left on");
  property p_pd; (LINK_UP && SPEED100 && !FULL) [*3] |-> PATH_DELAY_VALUE == 8'h32; endproperty
  a_pd: assert property (p_pd) else $error("path delay wrong");
  property p_pz; SEND_PAUSE |-> FULL && $past(fl) && $past(BUF_LEVEL) >= HIGH; endproperty
  a_pz: assert property (p_pz) else $error("pause without cause");
  property p_p2; SEND_PAUSE |-> !pz; endproperty
  a_p2: assert property (p_p2) else $error("pause repeated");
  property p_rs; SEND_RESUME |-> pz; endproperty
  a_rs: assert property (p_rs) else $error("resume without pause");
  property p_co; fl && LINK_UP && !FULL && BUF_LEVEL >= HIGH |=> FORCE_COL; endproperty
  a_co: assert property (p_co) else $error("no forced collision");
  property p_cf; BUF_LEVEL < LOW |=> !FORCE_COL; endproperty
  a_cf: assert property (p_cf) else $error("collision held");
  property p_fo; !fl && !$past(fl) && !$past(fl, 2) |-> !SEND_PAUSE && !FORCE_COL; endproperty
  a_fo: assert property (p_fo) else $error("flow acts while off");
  c_pz: cover property (SEND_PAUSE);
  c_rs: cover property (SEND_RESUME);
  c_co: cover property ($rose(FORCE_COL));
endmodule : cpl_sva
bind cpl_port cpl_sva #(.AW(AW), .HIGH(HIGH), .LOW(LOW)) cpl_sva_i (.*);
`default_nettype wire

/* File: sim/cpl_partner.sv */
// Purpose: Far station model for cpl_port.
// Assumes: The bench picks the station kind.
// Notes:   Detect, pair, pulse and idle lines drop with the signal; the page and hold lines follow a cycle or two later.
`default_nettype none
module cpl_partner (
  input wire logic       CLK, on, nego, swap, spd, MDIX, SEND_PAUSE, SEND_RESUME,
  input wire logic [3:0] adv,
  output logic           SIGNAL_DET, CROSS_OK, NLP_SEEN, IDLE_100, IDLE_10,
  output logic           PARTNER_VALID,
  output logic [3:0]     PARTNER_ADV
);
  logic [1:0] cnt;
  logic       held;
  // Signal is detected on either wiring; pairs match only when MDIX equals swap.
  assign SIGNAL_DET = on;
  assign CROSS_OK = on && (MDIX == swap);
  assign NLP_SEEN = on && nego;
  assign PARTNER_ADV = PARTNER_VALID ? adv : ~adv;
  assign IDLE_100 = on && !nego && spd;
  assign IDLE_10 = on && !nego && !spd;
  // pause holds sending; the page is valid four cycles after pairs match.
  always_ff @(posedge CLK) begin
    cnt <= (CROSS_OK && nego) ? cnt + {1'b0, cnt != 2'h3} : 2'h0;
    PARTNER_VALID <= cnt == 2'h3;
    held <= on && (SEND_PAUSE || (held && !SEND_RESUME));
  end
endmodule : cpl_partner
`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for cpl_port.
// Assumes: STARTUP shortened to 4 cycles.
// Notes:   Expectations come from bench functions.
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] HI = 10'h0380;
  localparam logic [9:0] LO = 10'h0200;
  int checked = 0, fail_count = 0, n0, nc = 0, i, k;
  logic CLK = 0, SYS_RST = 1, WR = 0, RD = 0, on = 0, nego = 0, swap = 0, spd = 0;
  logic fl, fd, pz = 0, ec = 0, MDIX, LINK_UP, SPEED100, FULL, NEGO_START;
  logic SEND_PAUSE, SEND_RESUME, FORCE_COL, SIGNAL_DET, CROSS_OK, NLP_SEEN;
  logic PARTNER_VALID, IDLE_100, IDLE_10;
  logic [3:0] ADDR = 0, adv = 0, l, p, PARTNER_ADV;
  logic [7:0] WDATA = 0, RDATA, PATH_DELAY_VALUE;
  logic [9:0] BUF_LEVEL = 0, sq[6] = '{HI - 10'h001, HI, 10'h03FF, LO, LO - 10'h001, HI};
  cpl_port #(.HIGH(HI), .LOW(LO), .STARTUP(4)) cpl_port_i (.*);
  cpl_partner cpl_partner_i (.*);
  // Clock and negotiation start counter.
  always #50 CLK = ~CLK;
  always @(posedge CLK) if (NEGO_START === 1'b1) nc++;
  function automatic logic [1:0] best(input logic [3:0] a);
    return a[3] ? 2'b11 : a[2] ? 2'b10 : a[1] ? 2'b01 : 2'b00;
  endfunction : best
  task automatic give_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // One bus cycle; a read compares the data of the next cycle.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    {WR, RD, ADDR, WDATA} <= {w, !w, a, d};
    @(posedge CLK);
    {WR, RD} <= 2'b00;
    #1;
    if (!w) `CHK(RDATA, d)
  endtask : bus
  // Drops the far station, then brings it back and waits for link.
  task automatic link(input logic n, s, input logic [3:0] a);
    @(posedge CLK) on <= 1'b0;
    repeat (6) @(posedge CLK);
    {nego, swap, spd, adv, on} <= {n, 1'($urandom), s, a, 1'b1};
    n0 = nc;
    for (i = 0; i < 400 && LINK_UP !== 1'b1; i++) begin
      @(posedge CLK);
      #1;
    end
    if (i == 400) begin fail_count++; give_verdict(); end
    repeat (3) @(posedge CLK);
    #1;
  endtask : link
  // Applies a buffer level and checks pause, resume and collision.
  task automatic lvl(input logic [9:0] v);
    logic ep, er;
    @(posedge CLK) BUF_LEVEL <= v;
    #1;
    `CHK(cpl_partner_i.held, pz)
    @(posedge CLK);
    #1;
    ep = fl && fd && !pz && v >= HI;
    er = fl && fd && pz && v < LO;
    ec = fl && !fd && (v >= HI || (ec && v >= LO));
    pz = ep || (pz && !er);
    `CHK(SEND_PAUSE, ep)
    `CHK(SEND_RESUME, er)
    `CHK(FORCE_COL, ec)
  endtask : lvl
  initial begin
    void'($urandom(16670));
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    bus(0, 4'h0, 8'h01);
    bus(0, 4'h8, 8'h0F);
    bus(1, 4'h2, 8'hAA);
    bus(0, 4'h2, 8'h00);
    $display("registers done");
    for (k = 0; k < 8; k++) begin
      l = (k == 0) ? 4'hF : 4'($urandom_range(15, 1));
      p = 4'($urandom) | (l & (~l + 4'h1));
      bus(1, 4'h8, {4'h0, l});
      bus(0, 4'h8, {4'h0, l});
      link(1, 1, p);
      `CHK({SPEED100, FULL}, best(l & p))
      `CHK(MDIX, swap)
      `CHK(nc > n0, 1'b1)
      `CHK(PATH_DELAY_VALUE, (best(l & p) == 2'b10) ? 8'h32 : 8'h00)
    end
    bus(1, 4'h8, 8'h0F);
    for (k = 0; k < 2; k++) begin
      link(0, k[0], 4'h0);
      `CHK({SPEED100, FULL}, {k[0], 1'b0})
      bus(1, 4'h0, {5'h00, k[0], 2'b10});
      link(0, 1, 4'h0);
      `CHK({SPEED100, FULL}, {1'b1, k[0]})
      bus(1, 4'h0, 8'h01);
    end
    $display("link modes done");
    for (k = 0; k < 2; k++) begin
      fd = !k[0];
      fl = 1'b0;
      link(1, 1, fd ? 4'h8 : 4'h4);
      lvl(HI);
      lvl(10'h000);
      bus(1, 4'h0, 8'h09);
      fl = 1'b1;
      foreach (sq[j]) lvl(sq[j]);
      bus(0, 4'h4, {3'h0, 1'b1, swap, 1'b1, fd, 1'b1});
      repeat (40) lvl(10'($urandom_range(10'h0390, 10'h01F0)));
      lvl(10'h000);
      bus(1, 4'h0, 8'h01);
    end
    $display("flow control done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
